// File: gpds_chk.sv
// Assertion checker for the gripper status block
`timescale 1ns/1ns
module gpds_chk (
	input wire        clk,
	input wire        reset,
	input wire [15:0] command_word,
	input wire [7:0]  tolerance_setting,
	input wire        boot_done,
	input wire        fault_event,
	input wire [15:0] state_flags_word,
	input wire        move_outer_req,
	input wire [7:0]  active_tolerance
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	boot_flag_a: assert property (
		boot_done |-> ##2 state_flags_word[6]) else $error("booted bit missing");
	xfer_ack_a: assert property (
		(command_word == 16'h0001) [*2] |=> state_flags_word[12]) else $error("no ack");
	ack_drop_a: assert property (
		(command_word != 16'h0001) [*2] |=> !state_flags_word[12]) else $error("ack stuck");
	param_hold_a: assert property (
		command_word != 16'h0001 |=> $stable(active_tolerance)) else $error("param moved");
	param_load_a: assert property (
		command_word == 16'h0001 && $past(command_word) != 16'h0001
		|=> active_tolerance == $past(tolerance_setting)) else $error("param not loaded");
	dir_clear_a: assert property (
		command_word == 16'h0004 |-> ##2 state_flags_word[14:13] == 2'b00) else $error("dir");
	fault_flag_a: assert property (
		fault_event |-> ##2 state_flags_word[15]) else $error("fault bit missing");
	repeat_move_a: assert property (
		command_word == 16'h0100 ##1 state_flags_word[13] |-> !move_outer_req) else $error("rep");
	cover property (command_word == 16'h0001 ##1 state_flags_word[12]);
	cover property (fault_event);
	cover property (move_outer_req);
endmodule // gpds_chk
bind gpds_core gpds_chk i_gpds_chk (.clk, .reset, .command_word, .tolerance_setting,
	.boot_done, .fault_event, .state_flags_word, .move_outer_req, .active_tolerance);

// File: gpds_consts.vh
// Constants for the gripper process-data and status block
`ifndef GPDS_CONSTS_VH
`define GPDS_CONSTS_VH

// Command word values, one bit each
`define GPDS_CMD_TRANSFER      16'h0001
`define GPDS_CMD_CLEAR_DIR     16'h0004
`define GPDS_CMD_MOVE_OUTER    16'h0100
`define GPDS_CMD_MOVE_INNER    16'h0200
`define GPDS_CMD_FAULT_ACK     16'h8000

// Status word bit positions
`define GPDS_ST_BOOTED         6
`define GPDS_ST_AT_OUTER       8
`define GPDS_ST_AT_PART        9
`define GPDS_ST_AT_INNER       10
`define GPDS_ST_UNDEFINED      11
`define GPDS_ST_XFER_ACK       12
`define GPDS_ST_DIR_OUTER      13
`define GPDS_ST_DIR_INNER      14
`define GPDS_ST_FAULT          15

// Parameter defaults and limits
`define GPDS_MAX_STROKE        16'h0C80
`define GPDS_RST_TOLERANCE     8'h00
`define GPDS_RST_FORCE         8'h01
`define GPDS_RST_PART_POS      16'h0000
`define GPDS_FORCE_MIN         8'h01
`define GPDS_FORCE_MAX         8'h04
`define GPDS_NO_FAULT          16'h0000

`endif

// File: gpds_core.v
// Process-data parameter and status logic of the gripper controller
// Notes on behaviour
// RQ1: Tolerance is 8-bit unsigned, 0..255, one count per 0.01 mm.
// RQ2: Acceptance window is expected position minus tolerance to plus tolerance.
// RQ3: Force level 8-bit, levels 1 to 4 select speed and current.
// RQ4: Expected position 16-bit unsigned, 0 to maximum stroke.
// RQ5: Jaws stopped within window set the position-matched status bit.
// RQ6: Bit 6 set once the controller has finished booting.
// RQ7: Bits 8, 9, 10 show outer, expected, inner position.
// RQ8: Bit 11 set when jaws are at no defined position.
// RQ9: Bit 12 acknowledges parameters taken over on command one.
// RQ10: Bit 13 last move outward, bit 14 last move inward.
// RQ11: Internal fault sets bit 15 and loads the fault code word.
// RQ12: Host clears resettable faults with command 0x8000.
// RQ13: Non-resettable faults persist after acknowledge while their cause remains.
// RQ14: Fault code is a read-only 16-bit word sent with status.
// RQ15: Jaw position is read-only 16-bit, 0 outer to stroke inner.
// RQ16: Host sends 0x01, awaits ack, then sends zero, awaits ack low.
// RQ17: Host sends zero or one defined command bit at a time.
// RQ18: Command 0x04 clears both direction flags.
// RQ19: Move repeated in a flagged direction is ignored until cleared.
// RQ20: Parameters latch into the active set only on transfer command.
// RQ21: Status bits 0 to 5 and 7 read zero.
`timescale 1ns/1ns
`include "gpds_consts.vh"
module gpds_core #(
	parameter [15:0] MAX_STROKE = `GPDS_MAX_STROKE
) (
	input  wire        clk,
	input  wire        reset,
	input  wire [15:0] command_word,
	input  wire [7:0]  tolerance_setting,
	input  wire [7:0]  force_level,
	input  wire [15:0] expected_part_position,
	input  wire        boot_done,
	input  wire [15:0] jaw_sensor_position,
	input  wire        jaws_stopped,
	input  wire        fault_event,
	input  wire        fault_resettable,
	input  wire [15:0] fault_event_code,
	input  wire        fault_cause_active,
	output reg  [15:0] state_flags_word,
	output reg  [15:0] fault_code_word,
	output reg  [15:0] jaw_position_now,
	output reg         move_outer_req,
	output reg         move_inner_req,
	output wire [7:0]  active_tolerance,
	output wire [7:0]  active_force_level,
	output wire [15:0] active_part_position
);
	reg         cmd_transfer;
	reg         cmd_clear_dir;
	reg         cmd_outer;
	reg         cmd_inner;
	reg         cmd_ack;

	reg         xfer_state;
	reg         next_xfer_state;
	wire        xfer_ack;
	wire        param_load;

	wire        force_ok;
	wire [7:0]  force_in;
	wire        part_too_far;
	wire [15:0] part_in;

	wire [16:0] win_low;
	wire [16:0] win_high;
	wire        in_window;
	wire        at_outer;
	wire        at_inner;
	wire        at_part;
	reg         pos_outer;
	reg         pos_inner;
	reg         part_match;

	reg         booted;
	reg         dir_outer;
	reg         dir_inner;
	reg         next_dir_outer;
	reg         next_dir_inner;
	reg         next_move_outer;
	reg         next_move_inner;

	reg         fault_flag;
	reg         fault_sticky;
	reg  [15:0] fault_code;
	reg         next_fault_flag;
	reg         next_fault_sticky;
	reg  [15:0] next_fault_code;

	reg  [15:0] next_status;
	wire        jaw_too_far;
	wire [15:0] jaw_clipped;

	localparam [0:0] XFER_IDLE  = 1'b0;
	localparam [0:0] XFER_TAKEN = 1'b1;

	// Exact-value decode: a word with two bits set, or an unlisted one, does nothing
	always @* begin
		cmd_transfer  = 1'b0;
		cmd_clear_dir = 1'b0;
		cmd_outer     = 1'b0;
		cmd_inner     = 1'b0;
		cmd_ack       = 1'b0;
		case (command_word)
			`GPDS_CMD_TRANSFER: begin
				cmd_transfer = 1'b1;
			end
			`GPDS_CMD_CLEAR_DIR: begin
				cmd_clear_dir = 1'b1;
			end
			`GPDS_CMD_MOVE_OUTER: begin
				cmd_outer = 1'b1;
			end
			`GPDS_CMD_MOVE_INNER: begin
				cmd_inner = 1'b1;
			end
			`GPDS_CMD_FAULT_ACK: begin
				cmd_ack = 1'b1;
			end
			default: begin
				cmd_transfer = 1'b0;
			end
		endcase
	end

	// Latch on the first cycle of a transfer only, so ack follows the take-over
	always @* begin
		case (xfer_state)
			XFER_IDLE: begin
				if (cmd_transfer)
					next_xfer_state = XFER_TAKEN;
				else
					next_xfer_state = XFER_IDLE;
			end
			XFER_TAKEN: begin
				if (cmd_transfer)
					next_xfer_state = XFER_TAKEN;
				else
					next_xfer_state = XFER_IDLE;
			end
			default: begin
				next_xfer_state = XFER_IDLE;
			end
		endcase
	end

	assign param_load = cmd_transfer && (xfer_state == XFER_IDLE); // RQ20
	assign xfer_ack   = (xfer_state == XFER_TAKEN); // RQ9

	always @(posedge clk) begin
		if (reset)
			xfer_state <= XFER_IDLE;
		else
			xfer_state <= next_xfer_state; // RQ9
	end

	// Out-of-range force levels are held at the nearest legal level
	assign force_ok = (force_level >= `GPDS_FORCE_MIN) && (force_level <= `GPDS_FORCE_MAX); // RQ3
	assign force_in = force_ok ? force_level :
		((force_level < `GPDS_FORCE_MIN) ? `GPDS_FORCE_MIN : `GPDS_FORCE_MAX); // RQ3

	// Positions past the stroke are clipped to the stroke
	assign part_too_far = (expected_part_position > MAX_STROKE); // RQ4
	assign part_in      = part_too_far ? MAX_STROKE : expected_part_position; // RQ4

	gpds_param_reg #(.WIDTH(8), .RESET_VALUE(`GPDS_RST_TOLERANCE)) u_tol (
		.clk       (clk),
		.reset     (reset),
		.load      (param_load), // RQ20
		.new_value (tolerance_setting), // RQ1
		.value     (active_tolerance)
	);
	gpds_param_reg #(.WIDTH(8), .RESET_VALUE(`GPDS_RST_FORCE)) u_force (
		.clk       (clk),
		.reset     (reset),
		.load      (param_load), // RQ20
		.new_value (force_in), // RQ3
		.value     (active_force_level)
	);
	gpds_param_reg #(.WIDTH(16), .RESET_VALUE(`GPDS_RST_PART_POS)) u_pos (
		.clk       (clk),
		.reset     (reset),
		.load      (param_load), // RQ20
		.new_value (part_in), // RQ4
		.value     (active_part_position)
	);

	// 17-bit window so the high edge cannot wrap; the compare makes the low edge saturate at zero
	assign win_low  = ({1'b0, active_part_position} > {9'h000, active_tolerance}) ?
		({1'b0, active_part_position} - {9'h000, active_tolerance}) : 17'h0_0000; // RQ2
	assign win_high = {1'b0, active_part_position} + {9'h000, active_tolerance}; // RQ2
	assign in_window = ({1'b0, jaw_sensor_position} >= win_low) &&
		({1'b0, jaw_sensor_position} <= win_high); // RQ2

	assign at_outer = jaws_stopped && (jaw_sensor_position <= {8'h00, active_tolerance}); // RQ7
	assign at_inner = jaws_stopped &&
		({1'b0, jaw_sensor_position} + {9'h000, active_tolerance} >= {1'b0, MAX_STROKE}); // RQ7
	assign at_part  = jaws_stopped && in_window; // RQ5

	// Registered together so bits 8 to 11 never disagree for a cycle
	always @(posedge clk) begin
		if (reset) begin
			pos_outer  <= 1'b0;
			pos_inner  <= 1'b0;
			part_match <= 1'b0;
		end else begin
			pos_outer  <= at_outer; // RQ7
			pos_inner  <= at_inner; // RQ7
			part_match <= at_part; // RQ5
		end
	end

	always @(posedge clk) begin
		if (reset)
			booted <= 1'b0;
		else if (boot_done)
			booted <= 1'b1; // RQ6
	end

	// Repeats in a flagged direction are dropped to reject line glitches
	always @* begin
		next_dir_outer  = dir_outer;
		next_dir_inner  = dir_inner;
		next_move_outer = 1'b0;
		next_move_inner = 1'b0;
		if (cmd_clear_dir) begin
			next_dir_outer = 1'b0; // RQ18
			next_dir_inner = 1'b0; // RQ18
		end else if (cmd_outer && !dir_outer) begin
			next_dir_outer  = 1'b1; // RQ10
			next_dir_inner  = 1'b0;
			next_move_outer = 1'b1; // RQ19
		end else if (cmd_inner && !dir_inner) begin
			next_dir_inner  = 1'b1; // RQ10
			next_dir_outer  = 1'b0;
			next_move_inner = 1'b1; // RQ19
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			dir_outer      <= 1'b0;
			dir_inner      <= 1'b0;
			move_outer_req <= 1'b0;
			move_inner_req <= 1'b0;
		end else begin
			dir_outer      <= next_dir_outer; // RQ10
			dir_inner      <= next_dir_inner; // RQ10
			move_outer_req <= next_move_outer; // RQ19
			move_inner_req <= next_move_inner; // RQ19
		end
	end

	// Fault: a new event wins over an acknowledge in the same cycle
	always @* begin
		next_fault_flag   = fault_flag;
		next_fault_sticky = fault_sticky;
		next_fault_code   = fault_code;
		if (fault_event) begin
			next_fault_flag   = 1'b1; // RQ11
			// A pending locked fault stays locked under a later resettable one
			next_fault_sticky = !fault_resettable || (fault_flag && fault_sticky); // RQ13
			next_fault_code   = fault_event_code; // RQ11
		end else if (fault_flag && fault_sticky && !fault_cause_active) begin
			next_fault_flag   = 1'b0; // RQ13
			next_fault_sticky = 1'b0;
			next_fault_code   = `GPDS_NO_FAULT;
		end else if (cmd_ack && fault_flag && !fault_sticky) begin
			next_fault_flag = 1'b0; // RQ12
			next_fault_code = `GPDS_NO_FAULT;
		end
	end

	always @(posedge clk) begin
		if (reset) begin
			fault_flag   <= 1'b0;
			fault_sticky <= 1'b0;
			fault_code   <= `GPDS_NO_FAULT;
		end else begin
			fault_flag   <= next_fault_flag; // RQ11
			fault_sticky <= next_fault_sticky; // RQ13
			fault_code   <= next_fault_code; // RQ11
		end
	end

	// Unused bits are cleared first so every path leaves them at zero
	always @* begin
		next_status                     = 16'h0000; // RQ21
		next_status[`GPDS_ST_BOOTED]    = booted; // RQ6
		next_status[`GPDS_ST_AT_OUTER]  = pos_outer; // RQ7
		next_status[`GPDS_ST_AT_PART]   = part_match; // RQ5
		next_status[`GPDS_ST_AT_INNER]  = pos_inner; // RQ7
		next_status[`GPDS_ST_UNDEFINED] = !(pos_outer || part_match || pos_inner); // RQ8
		next_status[`GPDS_ST_XFER_ACK]  = xfer_ack; // RQ9
		next_status[`GPDS_ST_DIR_OUTER] = dir_outer; // RQ10
		next_status[`GPDS_ST_DIR_INNER] = dir_inner; // RQ10
		next_status[`GPDS_ST_FAULT]     = fault_flag; // RQ11
	end

	assign jaw_too_far = (jaw_sensor_position > MAX_STROKE); // RQ15
	assign jaw_clipped = jaw_too_far ? MAX_STROKE : jaw_sensor_position; // RQ15

	always @(posedge clk) begin
		if (reset) begin
			state_flags_word <= 16'h0000;
			fault_code_word  <= `GPDS_NO_FAULT;
			jaw_position_now <= 16'h0000;
		end else begin
			state_flags_word <= next_status; // RQ6
			fault_code_word  <= fault_code; // RQ14
			jaw_position_now <= jaw_clipped; // RQ15
		end
	end
endmodule // gpds_core

// File: gpds_param_reg.v
// Active parameter register, loaded only on a transfer strobe
`timescale 1ns/1ns
module gpds_param_reg #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	input  wire             clk,
	input  wire             reset,
	input  wire             load,
	input  wire [WIDTH-1:0] new_value,
	output reg  [WIDTH-1:0] value
);
	always @(posedge clk) begin
		if (reset)
			value <= RESET_VALUE;
		else if (load)
			value <= new_value;
	end
endmodule // gpds_param_reg

// File: gpds_plc.sv
// Host model driving the command word
`timescale 1ns/1ns
module gpds_plc (
	input  wire         clk,
	input  wire  [15:0] cmd,
	input  wire  [15:0] state_flags_word,
	output logic [15:0] command_word,
	output logic        busy
);
	initial begin
		command_word = 16'h0000;
		busy         = 1'b0;
	end
	// Zero or one command bit, copied from the bench while idle
	always @(posedge clk) begin
		if (busy) begin
			if (state_flags_word[12])
				command_word <= 16'h0000;
			else if (command_word == 16'h0000)
				busy <= 1'b0;
		end else begin
			command_word <= cmd;
			busy <= (cmd == 16'h0001);
		end
	end
endmodule // gpds_plc

// File: testbench.sv
// Self-checking bench for the gripper status block
`timescale 1ns/1ns
module testbench;
	logic        clk = 0, reset = 1, boot_done = 0, jaws_stopped = 0, fault_event = 0;
	logic        fault_resettable = 0, fault_cause_active = 0;
	logic [15:0] cmd = 0, jaw_sensor_position = 0, expected_part_position = 0;
	logic [15:0] fault_event_code = 0;
	logic [7:0]  tolerance_setting = 0, force_level = 1;
	wire  [15:0] command_word, state_flags_word, fault_code_word, jaw_position_now;
	wire  [15:0] active_part_position;
	wire  [7:0]  active_tolerance, active_force_level;
	wire         busy, move_outer_req, move_inner_req;
	integer      miscompares = 0, compares = 0, ticks = 0, i;
	integer      outer_moves = 0, inner_moves = 0;
	logic [19:0] tab [0:5];
	always #2 clk = ~clk;
	// Move requests are one-cycle pulses, counted where they are settled
	always @(negedge clk) begin
		if (move_outer_req === 1'b1)
			outer_moves = outer_moves + 1;
		if (move_inner_req === 1'b1)
			inner_moves = inner_moves + 1;
	end
	gpds_plc i_gpds_plc (.clk, .cmd, .state_flags_word, .command_word, .busy);
	gpds_core i_gpds_core (.clk, .reset, .command_word, .tolerance_setting, .force_level,
		.expected_part_position, .boot_done, .jaw_sensor_position, .jaws_stopped,
		.fault_event, .fault_resettable, .fault_event_code, .fault_cause_active,
		.state_flags_word, .fault_code_word, .jaw_position_now, .move_outer_req,
		.move_inner_req, .active_tolerance, .active_force_level, .active_part_position);
	task wait_n(input integer n);
		repeat (n) @(negedge clk);
	endtask
	task chk(input [79:0] what, input [15:0] exp, input [15:0] got);
		compares = compares + 1;
		if (got !== exp) begin
			miscompares = miscompares + 1;
			$display("MISMATCH %0s expected %h seen %h", what, exp, got);
		end
	endtask
	// Transfers wait for the host model to finish, others are held a few cycles
	task send(input [15:0] c);
		cmd = c;
		wait_n(4);
		cmd = 16'h0000;
		for (i = 0; i < 30 && busy !== 1'b0; i = i + 1)
			wait_n(1);
		wait_n(3);
	endtask
	task fault(input r);
		fault_resettable = r;
		fault_cause_active = !r;
		fault_event_code = 16'h0300 + r;
		fault_event = 1;
		wait_n(1);
		fault_event = 0;
		wait_n(3);
		chk("fault", 16'h8000, state_flags_word & 16'h8000);
		chk("code", fault_event_code, fault_code_word);
		send(16'h8000);
		chk("acked", r ? 16'h0000 : 16'h8000, state_flags_word & 16'h8000);
		fault_cause_active = 0;
		wait_n(4);
		chk("gone", 16'h0000, state_flags_word & 16'h8000);
	endtask
	task wrap_up;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	always @(posedge clk) begin
		ticks = ticks + 1;
		if (ticks == 3000) begin
			miscompares = miscompares + 1;
			wrap_up;
		end
	end
	initial begin
		tab = '{20'h0000_1, 20'h0546_2, 20'h0672_2, 20'h0545_8, 20'h0673_8, 20'h0C80_4};
		wait_n(8);
		reset = 0;
		boot_done = 1;
		wait_n(3);
		chk("low byte", 16'h0040, state_flags_word & 16'h00FF);
		tolerance_setting = 8'h96;
		force_level = 8'h03;
		expected_part_position = 16'h05DC;
		send(16'h0001);
		chk("tol", 16'h0096, {8'h00, active_tolerance});
		chk("force", 16'h0003, {8'h00, active_force_level});
		chk("part", 16'h05DC, active_part_position);
		tolerance_setting = 8'h10;
		wait_n(3);
		chk("tol held", 16'h0096, {8'h00, active_tolerance});
		tolerance_setting = 8'h96;
		force_level = 8'h09;
		send(16'h0001);
		chk("force max", 16'h0004, {8'h00, active_force_level});
		$display("test parameters done");
		jaws_stopped = 1;
		for (i = 0; i < 6; i = i + 1) begin
			jaw_sensor_position = tab[i][19:4];
			wait_n(3);
			chk("pos bits", {12'h000, tab[i][3:0]}, {12'h000, state_flags_word[11:8]});
			chk("jaw", tab[i][19:4], jaw_position_now);
		end
		jaws_stopped = 0;
		wait_n(3);
		chk("moving", 16'h0008, {12'h000, state_flags_word[11:8]});
		$display("test positions done");
		send(16'h0100);
		send(16'h0100);
		chk("outer req", 16'h0001, outer_moves[15:0]);
		chk("dir out", 16'h2000, state_flags_word & 16'h6000);
		send(16'h0200);
		chk("dir in", 16'h4000, state_flags_word & 16'h6000);
		chk("inner req", 16'h0001, inner_moves[15:0]);
		send(16'h0004);
		chk("dir clr", 16'h0000, state_flags_word & 16'h6000);
		$display("test moves done");
		fault(1);
		fault(0);
		$display("test faults done");
		wrap_up;
	end
endmodule // testbench
